//--- nvm_store_ctrl.v
// User NVM store, reload and bulk programming command engine
`include "nvm_store_regs.vh"

module nvm_store_ctrl #(
   parameter ADDR_W = 6,
   parameter USER_WORDS = 64,
   parameter [15:0] PACKING_REV = 16'h0001, // Arbitrary value
   parameter PROG_CYCLES = `NVM_PROG_CYCLES,
   parameter ERASE_CYCLES = `NVM_ERASE_CYCLES
)(
   input wire clk,
   input wire rst_n,
   input wire reset_pin_n,
   input wire cmd_valid,
   output wire cmd_ready,
   input wire cmd_wr,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   output reg cmd_ack_q,
   output reg cmd_nack_q,
   output wire rd_valid,
   input wire rd_ready,
   output wire [15:0] rd_data,
   output wire [ADDR_W-1:0] ram_addr,
   output reg ram_wr_q,
   output reg [15:0] ram_wdata_q,
   input wire [15:0] ram_rdata,
   output wire not_busy,
   output reg pec_required_q,
   output wire monitor_hold
);

   ////////////////////////////////////////////////////////////////////////////
   // States
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_SAVE = 3'd1;
   localparam [2:0] ST_LOAD = 3'd2;
   localparam [2:0] ST_ERASE = 3'd3;
   localparam [2:0] ST_PROG = 3'd4;

   localparam [2:0] LK_LOCKED = 3'd0;
   localparam [2:0] LK_GOT_FIRST = 3'd1;
   localparam [2:0] LK_GOT_MID = 3'd2;
   localparam [2:0] LK_RW = 3'd3;
   localparam [2:0] LK_RO = 3'd4;

   localparam [1:0] DIR_NONE = 2'd0;
   localparam [1:0] DIR_RD = 2'd1;
   localparam [1:0] DIR_WR = 2'd2;

   localparam [15:0] WORDS16 = USER_WORDS;

   function key_pec;
      input [7:0] k;
      begin
         key_pec = k[0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage and state
   reg [15:0] ee_q [0:USER_WORDS-1];
   reg [2:0] state_q;
   reg [2:0] lock_q;
   reg [1:0] dir_q;
   reg [31:0] wait_q;
   reg [ADDR_W-1:0] idx_q;
   reg [ADDR_W-1:0] wr_addr_q;
   reg [15:0] ptr_q;
   reg [7:0] key_last_q;
   reg [7:0] erase_last_q;
   reg erased_q;
   reg rp_meta_q;
   reg rp_sync_q;
   reg rp_prev_q;
   reg [15:0] fifo_q [0:1];
   reg fifo_wp_q;
   reg fifo_rp_q;
   reg [1:0] fifo_cnt_q;
   reg push;
   reg [15:0] push_data;
   integer i;

   // Last reload strobe trails the state change by one cycle
   wire busy = (state_q != ST_IDLE) || ram_wr_q;
   wire take = cmd_valid && cmd_ready;
   wire status_rd = !cmd_wr && (cmd_code == `NVM_CMD_STATUS);
   wire last_idx = (idx_q == USER_WORDS - 1);
   wire wait_done = (wait_q == 32'h00000000);
   wire pop = rd_valid && rd_ready;
   wire [15:0] data_idx = ptr_q - `NVM_PTR_DATA0;

   // Reads land in the buffer a cycle late, so count the word in flight
   assign cmd_ready = (fifo_cnt_q == 2'd0) || (fifo_cnt_q == 2'd1 && !push);
   assign rd_valid = (fifo_cnt_q != 2'd0);
   assign rd_data = fifo_q[fifo_rp_q];
   assign not_busy = !busy;
   assign monitor_hold = (state_q == ST_LOAD) || ram_wr_q;
   // Write address follows the registered strobe, read address the counter
   assign ram_addr = ram_wr_q ? wr_addr_q : idx_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reset pin synchroniser; the released edge triggers a reload only while the engine is idle
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         rp_meta_q <= 1'b1;
         rp_sync_q <= 1'b1;
         rp_prev_q <= 1'b1;
      end
      else
      begin
         rp_meta_q <= reset_pin_n;
         rp_sync_q <= rp_meta_q;
         rp_prev_q <= rp_sync_q;
      end
   end

   wire pin_release = rp_sync_q && !rp_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry read buffer
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         fifo_wp_q <= 1'b0;
         fifo_rp_q <= 1'b0;
         fifo_cnt_q <= 2'd0;
      end
      else
      begin
         if (push)
         begin
            fifo_q[fifo_wp_q] <= push_data;
            fifo_wp_q <= !fifo_wp_q;
         end
         if (pop)
            fifo_rp_q <= !fifo_rp_q;
         if (push && !pop)
            fifo_cnt_q <= fifo_cnt_q + 2'd1;
         else if (pop && !push)
            fifo_cnt_q <= fifo_cnt_q - 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command engine
   always @(posedge clk)
   begin
      push <= 1'b0;
      push_data <= 16'h0000;
      cmd_ack_q <= 1'b0;
      cmd_nack_q <= 1'b0;
      ram_wr_q <= 1'b0;
      if (!rst_n)
      begin
         state_q <= ST_LOAD;
         lock_q <= LK_LOCKED;
         dir_q <= DIR_NONE;
         wait_q <= 32'h00000000;
         idx_q <= {ADDR_W{1'b0}};
         ptr_q <= 16'h0000;
         key_last_q <= 8'h00;
         erase_last_q <= 8'h00;
         erased_q <= 1'b0;
         pec_required_q <= 1'b0;
         ram_wdata_q <= 16'h0000;
         wr_addr_q <= {ADDR_W{1'b0}};
         push <= 1'b0;
         cmd_ack_q <= 1'b0;
         cmd_nack_q <= 1'b0;
         ram_wr_q <= 1'b0;
      end
      else
      begin
         // Background transfers
         case (state_q)
            ST_IDLE:
            begin
               if (pin_release)
               begin
                  state_q <= ST_LOAD;
                  idx_q <= {ADDR_W{1'b0}};
               end
            end
            ST_SAVE:
            begin
               if (wait_done)
               begin
                  ee_q[idx_q] <= ram_rdata;
                  wait_q <= PROG_CYCLES - 1;
                  idx_q <= idx_q + 1'b1;
                  if (last_idx)
                  begin
                     state_q <= ST_PROG;
                     idx_q <= {ADDR_W{1'b0}};
                  end
               end
               else
                  wait_q <= wait_q - 1;
            end
            ST_LOAD:
            begin
               ram_wr_q <= 1'b1;
               ram_wdata_q <= ee_q[idx_q];
               wr_addr_q <= idx_q;
               idx_q <= idx_q + 1'b1;
               if (last_idx)
               begin
                  state_q <= ST_IDLE;
                  idx_q <= {ADDR_W{1'b0}};
               end
            end
            ST_ERASE, ST_PROG:
            begin
               // Program time of the last word, or the whole erase time
               if (wait_done)
                  state_q <= ST_IDLE;
               else
                  wait_q <= wait_q - 1;
            end
            default:
               state_q <= ST_IDLE;
         endcase

         if (take)
         begin
            if (status_rd)
            begin
               cmd_ack_q <= 1'b1;
               push <= 1'b1;
               push_data <= 16'h0000;
               push_data[`NVM_STAT_NOT_BUSY] <= !busy;
               push_data[`NVM_STAT_PEC_REQ] <= pec_required_q;
            end
            else if (busy)
               cmd_nack_q <= 1'b1;
            else
            begin
               cmd_ack_q <= 1'b1;
               case (cmd_code)
                  `NVM_CMD_SAVE:
                  begin
                     if (cmd_wr)
                     begin
                        state_q <= ST_SAVE;
                        idx_q <= {ADDR_W{1'b0}};
                        wait_q <= 32'h00000000;
                     end
                     else
                     begin
                        cmd_ack_q <= 1'b0;
                        cmd_nack_q <= 1'b1;
                        push <= 1'b1;
                     end
                  end
                  `NVM_CMD_RELOAD:
                  begin
                     if (cmd_wr)
                     begin
                        state_q <= ST_LOAD;
                        idx_q <= {ADDR_W{1'b0}};
                     end
                     else
                     begin
                        cmd_ack_q <= 1'b0;
                        cmd_nack_q <= 1'b1;
                        push <= 1'b1;
                     end
                  end
                  `NVM_CMD_UNLOCK:
                  begin
                     if (cmd_wr)
                     begin
                        key_last_q <= cmd_wdata[7:0];
                        lock_q <= LK_LOCKED;
                        if (cmd_wdata[7:0] == `NVM_KEY_FIRST)
                           lock_q <= LK_GOT_FIRST;
                        else if (lock_q == LK_GOT_FIRST &&
                                 (cmd_wdata[7:0] == `NVM_KEY_RW_OPT ||
                                  cmd_wdata[7:0] == `NVM_KEY_RW_REQ))
                        begin
                           lock_q <= LK_RW;
                           pec_required_q <= key_pec(cmd_wdata[7:0]);
                           ptr_q <= 16'h0000;
                           dir_q <= DIR_NONE;
                           erased_q <= 1'b0;
                        end
                        else if (lock_q == LK_GOT_FIRST &&
                                 cmd_wdata[7:0] == `NVM_KEY_RO_MID)
                           lock_q <= LK_GOT_MID;
                        else if (lock_q == LK_GOT_MID &&
                                 (cmd_wdata[7:0] == `NVM_KEY_RO_OPT ||
                                  cmd_wdata[7:0] == `NVM_KEY_RO_REQ))
                        begin
                           lock_q <= LK_RO;
                           pec_required_q <= key_pec(cmd_wdata[7:0]);
                           ptr_q <= 16'h0000;
                           dir_q <= DIR_NONE;
                        end
                     end
                     else
                     begin
                        push <= 1'b1;
                        push_data <= {8'h00,
                                      (lock_q == LK_LOCKED) ? 8'h00 : key_last_q};
                     end
                  end
                  `NVM_CMD_ERASE:
                  begin
                     if (cmd_wr)
                     begin
                        erase_last_q <= cmd_wdata[7:0];
                        if (lock_q == LK_RW && cmd_wdata[7:0] == `NVM_KEY_ERASE)
                        begin
                           for (i = 0; i < USER_WORDS; i = i + 1)
                              ee_q[i] <= `NVM_ERASED_WORD;
                           erased_q <= 1'b1;
                           ptr_q <= 16'h0000;
                           state_q <= ST_ERASE;
                           wait_q <= ERASE_CYCLES - 1;
                        end
                        else
                           lock_q <= LK_LOCKED;
                     end
                     else
                     begin
                        push <= 1'b1;
                        push_data <= {8'h00, erase_last_q};
                     end
                  end
                  `NVM_CMD_WORD:
                  begin
                     if (lock_q != LK_RW && lock_q != LK_RO)
                     begin
                        cmd_ack_q <= 1'b0;
                        cmd_nack_q <= 1'b1;
                        if (!cmd_wr)
                        begin
                           push <= 1'b1;
                           push_data <= 16'h0000;
                        end
                     end
                     else if (!cmd_wr)
                     begin
                        push <= 1'b1;
                        ptr_q <= ptr_q + 16'h0001;
                        dir_q <= DIR_RD;
                        if (dir_q == DIR_WR)
                        begin
                           push_data <= 16'h0000;
                           lock_q <= LK_LOCKED;
                        end
                        else if (ptr_q == `NVM_PTR_REVISION)
                           push_data <= PACKING_REV;
                        else if (ptr_q == `NVM_PTR_COUNT)
                           push_data <= WORDS16;
                        else if (data_idx < WORDS16)
                           push_data <= ee_q[data_idx[ADDR_W-1:0]];
                        else
                        begin
                           push_data <= 16'h0000;
                           lock_q <= LK_LOCKED;
                        end
                     end
                     else if (lock_q == LK_RW && erased_q && dir_q != DIR_RD &&
                              ptr_q < WORDS16)
                     begin
                        ee_q[ptr_q[ADDR_W-1:0]] <= cmd_wdata;
                        ptr_q <= ptr_q + 16'h0001;
                        dir_q <= DIR_WR;
                        state_q <= ST_PROG;
                        wait_q <= PROG_CYCLES - 1;
                     end
                     else
                        lock_q <= LK_LOCKED;
                  end
                  default:
                  begin
                     cmd_ack_q <= 1'b0;
                     cmd_nack_q <= 1'b1;
                     if (!cmd_wr)
                     begin
                        push <= 1'b1;
                        push_data <= 16'h0000;
                     end
                  end
               endcase
            end
         end
      end
   end

endmodule

//--- nvm_store_regs.vh
// Command codes, unlock keys, field positions and timing for the user NVM store block
`ifndef NVM_STORE_REGS_VH
`define NVM_STORE_REGS_VH

// Command codes seen on the serial link
`define NVM_CMD_SAVE 8'h15
`define NVM_CMD_RELOAD 8'h16
`define NVM_CMD_UNLOCK 8'hBD
`define NVM_CMD_ERASE 8'hBE
`define NVM_CMD_WORD 8'hBF
`define NVM_CMD_STATUS 8'hEF

// Unlock and erase keys
`define NVM_KEY_FIRST 8'h2B
`define NVM_KEY_RW_OPT 8'hD4
`define NVM_KEY_RW_REQ 8'hD5
`define NVM_KEY_RO_MID 8'h91
`define NVM_KEY_RO_OPT 8'hE4
`define NVM_KEY_RO_REQ 8'hE5
`define NVM_KEY_ERASE 8'h2B

// Status byte layout
`define NVM_STAT_NOT_BUSY 6
`define NVM_STAT_PEC_REQ 0

// Word port header positions
`define NVM_PTR_REVISION 16'h0000
`define NVM_PTR_COUNT 16'h0001
`define NVM_PTR_DATA0 16'h0002

// Timing
`define NVM_CLK_MHZ 10
`define NVM_PROG_TIME_NS 510000
`define NVM_ERASE_TIME_MS 400
`define NVM_PROG_CYCLES ((`NVM_PROG_TIME_NS * `NVM_CLK_MHZ + 999) / 1000)
`define NVM_ERASE_CYCLES (`NVM_ERASE_TIME_MS * `NVM_CLK_MHZ * 1000)

// Erased cell value
`define NVM_ERASED_WORD 16'hFFFF

`endif

//--- nvm_store_checker.sv
// Port checks on the NVM store command engine
`include "nvm_store_regs.vh"
module nvm_store_checker #(
   parameter ADDR_W = 6
)(
   input wire clk,
   input wire rst_n,
   input wire cmd_valid,
   input wire cmd_ready,
   input wire cmd_wr,
   input wire [7:0] cmd_code,
   input wire cmd_ack_q,
   input wire cmd_nack_q,
   input wire rd_valid,
   input wire [15:0] rd_data,
   input wire [ADDR_W-1:0] ram_addr,
   input wire ram_wr_q,
   input wire not_busy,
   input wire pec_required_q,
   input wire monitor_hold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire take = cmd_valid && cmd_ready;
   wire st_rd = take && !cmd_wr && cmd_code == `NVM_CMD_STATUS;
   a_answer_once: assert property (take |=> cmd_ack_q != cmd_nack_q)
      else $error("command without single answer");
   a_no_stray: assert property (!take |=> !cmd_ack_q && !cmd_nack_q)
      else $error("answer without command");
   a_busy_refused: assert property (take && !not_busy && !st_rd |=> cmd_nack_q)
      else $error("command taken while busy");
   a_status_ack: assert property (st_rd |=> cmd_ack_q)
      else $error("status read refused");
   a_status_value: assert property (st_rd && !rd_valid |-> ##2
      rd_data == {9'h000, $past(not_busy, 2), 5'h00, $past(pec_required_q, 2)})
      else $error("status byte wrong");
   a_reload_holds: assert property (ram_wr_q |-> monitor_hold && !not_busy)
      else $error("memory written outside reload");
   a_reload_walk: assert property (take && cmd_wr && cmd_code == `NVM_CMD_RELOAD && not_busy
      |=> ##1 ram_wr_q[*8])
      else $error("reload did not stream words");
   a_addr_steps: assert property (ram_wr_q && $past(ram_wr_q) |->
      ram_addr == $past(ram_addr) + 1'b1)
      else $error("reload address skipped");
   a_save_busy: assert property (take && cmd_wr && cmd_code == `NVM_CMD_SAVE && not_busy
      |=> !not_busy[*3])
      else $error("save not busy");
   a_reset_busy: assert property ($rose(rst_n) |-> !not_busy && monitor_hold)
      else $error("no reload after reset");
   c_save: cover property (take && cmd_wr && cmd_code == `NVM_CMD_SAVE);
   c_reload: cover property (take && cmd_wr && cmd_code == `NVM_CMD_RELOAD);
   c_busy_status: cover property (st_rd && !not_busy);
endmodule

bind nvm_store_ctrl nvm_store_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
   .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q), .rd_valid(rd_valid), .rd_data(rd_data),
   .ram_addr(ram_addr), .ram_wr_q(ram_wr_q), .not_busy(not_busy),
   .pec_required_q(pec_required_q), .monitor_hold(monitor_hold));

//--- nvm_ram_model.sv
// Operating-memory model with same-cycle read
module nvm_ram_model #(
   parameter ADDR_W = 6
)(
   input wire clk,
   input wire [ADDR_W-1:0] ram_addr,
   input wire ram_wr_q,
   input wire [15:0] ram_wdata_q,
   output wire [15:0] ram_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:(1<<ADDR_W)-1];
   assign ram_rdata = mem[ram_addr];
   always @(posedge clk)
   begin
      if (ram_wr_q)
         mem[ram_addr] <= ram_wdata_q;
   end
endmodule

//--- tb.sv
// Self-checking bench for the NVM store command engine
`include "nvm_store_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam AW = 3;
   localparam NW = 8;
   localparam [15:0] REV = 16'h00A5; // Arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin_n = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_wr = 1'b0;
   logic [7:0] cmd_code = 8'h00;
   logic [15:0] cmd_wdata = 16'h0000;
   logic rd_ready = 1'b1;
   wire cmd_ready, ack, nack, rd_valid, ram_wr, not_busy, pec, hold;
   wire [15:0] rd_data, ram_wdata, ram_rdata;
   wire [AW-1:0] ram_addr;
   integer miscompares = 0;
   integer n_checks = 0;
   integer seed = 32'hf09b6801;
   integer cyc = 0;
   integer i;
   logic [1:0] ans;
   logic [15:0] r;
   logic [15:0] ram_exp [0:NW-1];
   logic [15:0] ee_exp [0:NW-1];
   ////////////////////////////////////////////////////////////////////////
   nvm_store_ctrl #(.ADDR_W(AW), .USER_WORDS(NW), .PACKING_REV(REV), .PROG_CYCLES(4),
      .ERASE_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .reset_pin_n(pin_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .cmd_ack_q(ack), .cmd_nack_q(nack), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .ram_addr(ram_addr), .ram_wr_q(ram_wr),
      .ram_wdata_q(ram_wdata), .ram_rdata(ram_rdata), .not_busy(not_busy),
      .pec_required_q(pec), .monitor_hold(hold));
   nvm_ram_model #(.ADDR_W(AW)) u_ram (.clk(clk), .ram_addr(ram_addr), .ram_wr_q(ram_wr),
      .ram_wdata_q(ram_wdata), .ram_rdata(ram_rdata));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task final_report;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input [15:0] e, input [15:0] g);
      n_checks = n_checks + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One request, held until taken; answer one cycle later, read word one more
   task cmd(input w, input [7:0] c, input [15:0] d);
      cmd_valid = 1'b1;
      cmd_wr = w;
      cmd_code = c;
      cmd_wdata = d;
      while (cmd_ready !== 1'b1)
         @(posedge clk) #1;
      @(posedge clk);
      #1 ans = {nack, ack};
      cmd_valid = 1'b0;
      @(posedge clk);
      #1 r = rd_data;
   endtask
   task poll;
      integer k;
      k = 0;
      r = 16'h0000;
      while (r[6] !== 1'b1 && k < 300)
      begin
         cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
         k = k + 1;
      end
      chk("idle", 16'h0001, {15'h0000, r[6]});
   endtask
   task unlock(input [7:0] k);
      cmd(1'b1, `NVM_CMD_UNLOCK, {8'h00, `NVM_KEY_FIRST});
      cmd(1'b1, `NVM_CMD_UNLOCK, {8'h00, k});
   endtask
   task key_is(input [7:0] e);
      cmd(1'b0, `NVM_CMD_UNLOCK, 16'h0000);
      chk("key", {8'h00, e}, r);
   endtask
   task ram_cmp;
      for (i = 0; i < NW; i = i + 1)
         chk("ram", ram_exp[i], u_ram.mem[i]);
   endtask
   task ram_scr;
      for (i = 0; i < NW; i = i + 1)
         u_ram.mem[i] = ~ram_exp[i];
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         miscompares = miscompares + 1;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      cmd(1'b0, `NVM_CMD_UNLOCK, 16'h0000);
      chk("busy_ans", 16'h0002, ans);
      cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
      chk("st_ans", 16'h0001, ans);
      chk("st_busy", 16'h0000, r[6]);
      poll;
      for (i = 0; i < NW; i = i + 1)
         ram_exp[i] = $random(seed);
      ram_cmp_init: for (i = 0; i < NW; i = i + 1)
         u_ram.mem[i] = ram_exp[i];
      cmd(1'b1, `NVM_CMD_SAVE, 16'h0000);
      chk("save_ans", 16'h0001, ans);
      cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
      chk("save_busy", 16'h0000, r[6]);
      poll;
      ram_scr;
      cmd(1'b1, `NVM_CMD_RELOAD, 16'h0000);
      poll;
      ram_cmp;
      ram_scr;
      pin_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 pin_n = 1'b1;
      repeat (5) @(posedge clk);
      #1 poll;
      ram_cmp;
      key_is(8'h00);
      cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
      chk("wp_locked", 16'h0002, ans);
      unlock(`NVM_KEY_RW_OPT);
      key_is(`NVM_KEY_RW_OPT);
      chk("pec_opt", 16'h0000, pec);
      cmd(1'b1, `NVM_CMD_ERASE, {8'h00, `NVM_KEY_ERASE});
      cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
      chk("erase_busy", 16'h0000, r[6]);
      poll;
      cmd(1'b0, `NVM_CMD_ERASE, 16'h0000);
      chk("erase_echo", {8'h00, `NVM_KEY_ERASE}, r);
      for (i = 0; i < NW; i = i + 1)
      begin
         ee_exp[i] = $random(seed);
         cmd(1'b1, `NVM_CMD_WORD, ee_exp[i]);
         chk("wr_ans", 16'h0001, ans);
         poll;
      end
      ram_cmp;
      cmd(1'b1, `NVM_CMD_WORD, 16'h1234);
      key_is(8'h00);
      unlock(`NVM_KEY_RW_REQ);
      chk("pec_req", 16'h0001, pec);
      cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
      chk("rev", REV, r);
      cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
      chk("count", NW, r);
      for (i = 0; i < NW; i = i + 1)
      begin
         cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
         chk("ee", ee_exp[i], r);
      end
      cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
      chk("past_end", 16'h0000, r);
      key_is(8'h00);
      for (i = 0; i < 2; i = i + 1)
      begin
         cmd(1'b1, `NVM_CMD_UNLOCK, {8'h00, `NVM_KEY_FIRST});
         cmd(1'b1, `NVM_CMD_UNLOCK, {8'h00, `NVM_KEY_RO_MID});
         cmd(1'b1, `NVM_CMD_UNLOCK, {8'h00, i ? `NVM_KEY_RO_REQ : `NVM_KEY_RO_OPT});
         chk("pec_ro", i, pec);
         cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
         chk("ro_rev", REV, r);
      end
      cmd(1'b1, `NVM_CMD_WORD, 16'h0000);
      key_is(8'h00);
      unlock(8'h77);
      key_is(8'h00);
      cmd(1'b0, `NVM_CMD_WORD, 16'h0000);
      chk("wp_relock", 16'h0002, ans);
      unlock(`NVM_KEY_RW_OPT);
      cmd(1'b1, `NVM_CMD_ERASE, 16'h005A);
      key_is(8'h00);
      cmd(1'b0, `NVM_CMD_ERASE, 16'h0000);
      chk("erase_last", 16'h005A, r);
      // Receiver stalls: two words must wait in the buffer
      @(posedge clk);
      #1 rd_ready = 1'b0;
      cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
      cmd(1'b0, `NVM_CMD_STATUS, 16'h0000);
      chk("full", 16'h0000, cmd_ready);
      chk("head", 16'h0040, rd_data);
      rd_ready = 1'b1;
      @(posedge clk);
      #1 chk("second", 16'h0001, rd_valid);
      chk("second_val", 16'h0040, rd_data);
      @(posedge clk);
      #1 chk("drained", 16'h0000, rd_valid);
      final_report;
   end
endmodule
